// *** verilog/pic_interlock.sv ***
// Pipeline interlock, data bus cycle sequencing and multiply early termination
// Operation
// RULE1 - Signed and short multiplies: m=1,2,3 when top 24/16/8 bits are all equal.
// RULE2 - Unsigned long multiplies: m=1,2,3 only when those top bits are zero.
// RULE3 - Multiplier register comes from bits 11:8, or 2:0 in compact code.
// RULE4 - Instruction fetches stop while an interlock is active.
// RULE5 - Use of a word from the preceding load stalls exactly one cycle.
// RULE6 - Use of a loaded byte or halfword stalls two cycles.
// RULE7 - Multi-register loads transfer lowest register first, highest last.
// RULE8 - Dependents on non-last registers wait until the final transfer begins.
// RULE9 - Dependents on the last register wait one further cycle.
// RULE10 - Data bus: single N; lists N then S beats; swap N+S; moves one C.
// RULE11 - Each data bus cycle is reported as N, S, I or C.
// RULE12 - m lies in 1..4 and adds to the multiply base count.
// RULE13 - Decode sources are compared with pending load destinations to stall.
`timescale 1ns/100ps
`default_nettype none
module pic_interlock
    import pic_pkg::*;
#(
    parameter int unsigned CP_WORDS_MAX = 16
)(
    // Clock and reset
    input  wire  logic                 i_ref_clk,
    input  wire  logic                 i_rst_b,
    // Decode stage
    input  wire  pic_dec_t             i_dec,
    input  wire  logic [31:0]          i_mul_operand,
    output logic                       o_issue,
    output logic                       o_fetch_en,
    output logic                       o_interlock,
    // Data bus cycle report
    output pic_dbus_t                  o_dbus,
    // Multiplier
    output logic [PIC_REG_W-1:0]       o_mul_reg_sel,
    output logic [2:0]                 o_mul_iter,
    output logic [2:0]                 o_mul_cycles
);
    if (CP_WORDS_MAX < 1 || CP_WORDS_MAX >= (1 << PIC_CNT_W)) begin : g_chk
        $error("CP_WORDS_MAX out of range");
    end

    localparam logic [PIC_CNT_W-1:0] CP_LIMIT = PIC_CNT_W'(CP_WORDS_MAX);

    function automatic logic uses(input pic_dec_t d, input logic [PIC_REG_W-1:0] r);
        return (d.src_en[0] && d.src_a == r) || (d.src_en[1] && d.src_b == r) ||
               (d.src_en[2] && d.src_c == r);
    endfunction

    function automatic logic uses_mask(input pic_dec_t d, input logic [PIC_NREG-1:0] m);
        return (d.src_en[0] && m[d.src_a]) || (d.src_en[1] && m[d.src_b]) ||
               (d.src_en[2] && m[d.src_c]);
    endfunction

    function automatic logic [PIC_REG_W-1:0] lowest(input logic [PIC_NREG-1:0] m);
        logic [PIC_REG_W-1:0] idx;
        idx = '0;
        for (int i = PIC_NREG - 1; i >= 0; i--) begin
            if (m[i]) idx = PIC_REG_W'(i);
        end
        return idx;
    endfunction

    function automatic logic [PIC_REG_W-1:0] highest(input logic [PIC_NREG-1:0] m);
        logic [PIC_REG_W-1:0] idx;
        idx = '0;
        for (int i = 0; i < PIC_NREG; i++) begin
            if (m[i]) idx = PIC_REG_W'(i);
        end
        return idx;
    endfunction

    function automatic logic [PIC_NREG-1:0] onehot(input logic [PIC_REG_W-1:0] r);
        return {{(PIC_NREG-1){1'b0}}, 1'b1} << r;
    endfunction

    function automatic logic [2:0] mul_iter(input logic [31:0] v, input logic uns);
        logic z8;
        logic z16;
        logic z24;
        logic o8;
        logic o16;
        logic o24;
        z8  = ~|v[31:PIC_ET_LO];
        z16 = ~|v[31:PIC_ET_MID];
        z24 = ~|v[31:PIC_ET_HI];
        o8  = &v[31:PIC_ET_LO];
        o16 = &v[31:PIC_ET_MID];
        o24 = &v[31:PIC_ET_HI];
        if (z8 || (!uns && o8)) return 3'h1;                               // RULE1 RULE2
        else if (z16 || (!uns && o16)) return 3'h2;                        // RULE1 RULE2
        else if (z24 || (!uns && o24)) return 3'h3;                        // RULE1 RULE2
        else return PIC_M_MAX;
    endfunction

    // Pipeline and data bus state
    logic                 issue_q, issue_d;
    logic                 fetch_q, fetch_d;
    logic                 ilock_q, ilock_d;
    pic_mst_t             mst_q, mst_d;
    logic [PIC_NREG-1:0]  rem_q, rem_d;
    logic [PIC_NREG-1:0]  list_q, list_d;
    logic [PIC_REG_W-1:0] last_q, last_d;
    logic                 ldm_q, ldm_d;
    logic                 cur_last_q, cur_last_d;
    logic [PIC_CNT_W-1:0] seq_q, seq_d;
    logic [PIC_REG_W-1:0] pend_dst_q, pend_dst_d;
    logic [1:0]           pend_cnt_q, pend_cnt_d;
    pic_dbus_t            dbus_q, dbus_d;
    // Multiplier state
    logic [PIC_REG_W-1:0] sel_q, sel_d;
    logic                 mpend_q, mpend_d;
    logic                 uns_q, uns_d;
    logic                 long_q, long_d;
    logic [2:0]           iter_q, iter_d;
    logic [2:0]           cyc_q, cyc_d;
    logic [2:0]           busy_q, busy_d;

    logic                 load_use;
    logic                 ldm_dep;
    logic                 interlock;
    logic                 mem_kind;
    logic                 mul_kind;
    logic                 mul_hold;
    logic [PIC_REG_W-1:0] lo;
    logic [PIC_CNT_W-1:0] words;

    assign mul_hold = mpend_q || (busy_q != 3'h0);
    assign mem_kind = i_dec.kind inside {KIND_SINGLE_WORD_LOAD, KIND_SINGLE_BYTE_LOAD,
        KIND_SINGLE_WORD_STORE, KIND_MULTI_REGISTER_LOAD, KIND_MULTI_REGISTER_STORE,
        KIND_ATOMIC_SWAP, KIND_COPROC_MEM_LOAD, KIND_COPROC_MEM_STORE,
        KIND_CORE_TO_COPROC_MOVE, KIND_COPROC_TO_CORE_MOVE};
    assign mul_kind = i_dec.kind inside {KIND_MULTIPLY_SHORT, KIND_MULTIPLY_ACCUMULATE_SHORT,
        KIND_SIGNED_LONG_MULTIPLY, KIND_SIGNED_LONG_MULTIPLY_ACC,
        KIND_UNSIGNED_LONG_MULTIPLY, KIND_UNSIGNED_LONG_MULTIPLY_ACC};

    always_comb
    begin
        load_use   = (pend_cnt_q != 2'h0) && uses(i_dec, pend_dst_q);            // RULE13
        ldm_dep    = ldm_q && ((rem_q != '0 && uses_mask(i_dec, list_q & ~onehot(last_q)))
                     || (uses(i_dec, last_q) && (rem_q != '0 || cur_last_q)));  // RULE8 RULE9
        interlock  = i_dec.valid && !issue_q && (load_use || ldm_dep);
        // Issue pulse blocks the next cycle so a held decode slot is never taken twice
        issue_d    = i_dec.valid && !issue_q && !interlock && !mul_hold &&
                     !(mem_kind && mst_q != MS_IDLE);
        fetch_d    = !interlock;                                                 // RULE4
        ilock_d    = interlock;
        mst_d      = mst_q;
        rem_d      = rem_q;
        list_d     = list_q;
        last_d     = last_q;
        ldm_d      = ldm_q;
        cur_last_d = 1'b0;
        seq_d      = seq_q;
        pend_dst_d = pend_dst_q;
        pend_cnt_d = (pend_cnt_q != 2'h0 && !issue_q) ? pend_cnt_q - 2'h1 : pend_cnt_q;
        dbus_d     = '{active: 1'b0, cyc: CYC_I, xfer_reg: '0};                  // RULE11
        lo         = '0;
        words      = (i_dec.cp_words > CP_LIMIT) ? CP_LIMIT : i_dec.cp_words;
        unique case (mst_q)
            MS_IDLE:
            begin
                if (issue_d && mem_kind) begin
                    ldm_d  = 1'b0;
                    dbus_d = '{active: 1'b1, cyc: CYC_N, xfer_reg: '0};          // RULE10
                    unique case (i_dec.kind)
                        KIND_SINGLE_WORD_LOAD, KIND_SINGLE_BYTE_LOAD:
                        begin
                            pend_dst_d = i_dec.src_c;
                            pend_cnt_d = (i_dec.kind == KIND_SINGLE_BYTE_LOAD) ?
                                         PIC_USE_BYTE : PIC_USE_WORD;            // RULE5 RULE6
                        end
                        KIND_MULTI_REGISTER_LOAD, KIND_MULTI_REGISTER_STORE:
                        begin
                            lo              = lowest(i_dec.reg_list);            // RULE7
                            dbus_d.xfer_reg = lo;
                            rem_d           = i_dec.reg_list & ~onehot(lo);
                            mst_d           = (rem_d != '0) ? MS_LIST : MS_IDLE;
                            if (i_dec.kind == KIND_MULTI_REGISTER_LOAD) begin
                                ldm_d      = 1'b1;
                                list_d     = i_dec.reg_list;
                                last_d     = highest(i_dec.reg_list);
                                cur_last_d = (rem_d == '0);
                            end
                        end
                        KIND_ATOMIC_SWAP:
                        begin
                            seq_d = PIC_CNT_W'(1);                               // RULE10
                            mst_d = MS_SEQ;
                        end
                        KIND_COPROC_MEM_LOAD, KIND_COPROC_MEM_STORE:
                        begin
                            seq_d = (words > '0) ? words - PIC_CNT_W'(1) : '0;
                            mst_d = (seq_d != '0) ? MS_SEQ : MS_IDLE;
                        end
                        KIND_CORE_TO_COPROC_MOVE, KIND_COPROC_TO_CORE_MOVE:
                        begin
                            dbus_d.cyc = CYC_C;                                  // RULE10
                        end
                        default:
                        begin
                        end
                    endcase
                end
            end
            MS_LIST:
            begin
                lo         = lowest(rem_q);                                      // RULE7
                dbus_d     = '{active: 1'b1, cyc: CYC_S, xfer_reg: lo};
                rem_d      = rem_q & ~onehot(lo);
                cur_last_d = ldm_q && (rem_d == '0);
                if (rem_d == '0) mst_d = MS_IDLE;
            end
            MS_SEQ:
            begin
                dbus_d = '{active: 1'b1, cyc: CYC_S, xfer_reg: '0};              // RULE10
                seq_d  = seq_q - PIC_CNT_W'(1);
                if (seq_q == PIC_CNT_W'(1)) mst_d = MS_IDLE;
            end
            default:
            begin
                mst_d = MS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b) begin
            issue_q    <= 1'b0;
            fetch_q    <= 1'b1;
            ilock_q    <= 1'b0;
            mst_q      <= MS_IDLE;
            rem_q      <= '0;
            list_q     <= '0;
            last_q     <= '0;
            ldm_q      <= 1'b0;
            cur_last_q <= 1'b0;
            seq_q      <= '0;
            pend_dst_q <= '0;
            pend_cnt_q <= 2'h0;
            dbus_q     <= '{active: 1'b0, cyc: CYC_I, xfer_reg: '0};
        end else begin
            issue_q    <= issue_d;
            fetch_q    <= fetch_d;
            ilock_q    <= ilock_d;
            mst_q      <= mst_d;
            rem_q      <= rem_d;
            list_q     <= list_d;
            last_q     <= last_d;
            ldm_q      <= ldm_d;
            cur_last_q <= cur_last_d;
            seq_q      <= seq_d;
            pend_dst_q <= pend_dst_d;
            pend_cnt_q <= pend_cnt_d;
            dbus_q     <= dbus_d;
        end
    end

    // Operand is read through the registered select, so m is settled one cycle after issue
    always_comb
    begin
        sel_d   = i_dec.compact ? PIC_REG_W'(i_dec.instr[PIC_COMPACT_SEL_W-1:0]) :
                  i_dec.instr[PIC_FULL_SEL_LSB +: PIC_REG_W];                    // RULE3
        mpend_d = issue_d && mul_kind;
        uns_d   = mpend_d ? i_dec.kind inside {KIND_UNSIGNED_LONG_MULTIPLY,
                  KIND_UNSIGNED_LONG_MULTIPLY_ACC} : uns_q;
        long_d  = mpend_d ? !(i_dec.kind inside {KIND_MULTIPLY_SHORT,
                  KIND_MULTIPLY_ACCUMULATE_SHORT}) : long_q;
        iter_d  = iter_q;
        cyc_d   = cyc_q;
        busy_d  = (busy_q != 3'h0) ? busy_q - 3'h1 : 3'h0;
        if (mpend_q) begin
            iter_d = mul_iter(i_mul_operand, uns_q);
            cyc_d  = (long_q ? PIC_BASE_LONG : PIC_BASE_SHORT) + iter_d;         // RULE12
            busy_d = cyc_d - PIC_BUSY_OFFSET;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_rst_b) begin
            sel_q   <= '0;
            mpend_q <= 1'b0;
            uns_q   <= 1'b0;
            long_q  <= 1'b0;
            iter_q  <= PIC_M_MIN;
            cyc_q   <= PIC_BASE_SHORT + PIC_M_MIN;
            busy_q  <= 3'h0;
        end else begin
            sel_q   <= sel_d;
            mpend_q <= mpend_d;
            uns_q   <= uns_d;
            long_q  <= long_d;
            iter_q  <= iter_d;
            cyc_q   <= cyc_d;
            busy_q  <= busy_d;
        end
    end

    assign o_issue       = issue_q;
    assign o_fetch_en    = fetch_q;
    assign o_interlock   = ilock_q;
    assign o_dbus        = dbus_q;
    assign o_mul_reg_sel = sel_q;
    assign o_mul_iter    = iter_q;
    assign o_mul_cycles  = cyc_q;

    chk_signed_early_m : assert property ( // RULE1
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        mpend_q && !uns_q && (&i_mul_operand[31:8] || ~|i_mul_operand[31:8])
        |=> o_mul_iter == 3'h1)
        else $error("signed multiply early termination wrong");
    chk_unsigned_no_ones : assert property ( // RULE2
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        mpend_q && uns_q && i_mul_operand[31] |=> o_mul_iter == 3'h4)
        else $error("unsigned multiply terminated early on ones");
    chk_mul_reg_sel : assert property ( // RULE3
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        !i_dec.compact |=> o_mul_reg_sel == $past(i_dec.instr[11:8]))
        else $error("multiplier register select wrong");
    chk_fetch_stop : assert property ( // RULE4
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        interlock |=> !o_fetch_en && o_interlock)
        else $error("fetch not stopped during interlock");
    chk_word_use_stall : assert property ( // RULE5
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        issue_d && i_dec.kind == KIND_SINGLE_WORD_LOAD
        |=> pend_cnt_q == 2'h1 ##1 pend_cnt_q == 2'h1 ##1 (o_issue || pend_cnt_q == 2'h0))
        else $error("word load-use window not one cycle");
    chk_byte_use_stall : assert property ( // RULE6
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        issue_d && i_dec.kind == KIND_SINGLE_BYTE_LOAD
        |=> pend_cnt_q == 2'h2 ##1 pend_cnt_q == 2'h2 ##1 (o_issue || pend_cnt_q == 2'h1)
        ##1 (o_issue || $past(o_issue) || pend_cnt_q == 2'h0))
        else $error("byte load-use window not two cycles");
    chk_list_ascending : assert property ( // RULE7
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        mst_q == MS_LIST |=> o_dbus.xfer_reg > $past(o_dbus.xfer_reg))
        else $error("register list not ascending");
    chk_list_hold : assert property ( // RULE8
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        ldm_q && rem_q != '0 && i_dec.valid && uses_mask(i_dec, list_q) |=> !o_issue)
        else $error("dependent issued before final transfer");
    chk_swap_beats : assert property ( // RULE10
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        issue_d && i_dec.kind == KIND_ATOMIC_SWAP
        |=> o_dbus.cyc == CYC_N ##1 o_dbus.cyc == CYC_S
        ##1 (!o_dbus.active || o_dbus.cyc == CYC_N))
        else $error("swap data bus cycles wrong");
    chk_move_c_cycle : assert property ( // RULE11
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        issue_d && i_dec.kind inside {KIND_CORE_TO_COPROC_MOVE, KIND_COPROC_TO_CORE_MOVE}
        |=> o_dbus.active && o_dbus.cyc == CYC_C ##1 !o_dbus.active)
        else $error("coprocessor move not one C cycle");
    chk_m_range : assert property ( // RULE12
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        o_mul_iter >= 3'h1 && o_mul_iter <= 3'h4)
        else $error("multiply iteration count out of range");
    chk_pending_match : assert property ( // RULE13
        @(posedge i_ref_clk) disable iff (!i_rst_b)
        i_dec.valid && pend_cnt_q != 2'h0 && uses(i_dec, pend_dst_q) |=> !o_issue)
        else $error("issued against pending load destination");
endmodule // pic_interlock
`default_nettype wire

// *** verilog/pic_pkg.sv ***
// Shared types and constants for the pipeline interlock and multiply timing block
`default_nettype none
package pic_pkg;
    localparam int unsigned PIC_REG_W         = 4;
    localparam int unsigned PIC_NREG          = 16;
    localparam int unsigned PIC_CNT_W         = 5;
    localparam int unsigned PIC_FULL_SEL_LSB  = 8;
    localparam int unsigned PIC_COMPACT_SEL_W = 3;
    localparam int unsigned PIC_ET_LO         = 8;
    localparam int unsigned PIC_ET_MID        = 16;
    localparam int unsigned PIC_ET_HI         = 24;
    localparam logic [2:0]  PIC_M_MIN         = 3'h1;
    localparam logic [2:0]  PIC_M_MAX         = 3'h4;
    localparam logic [2:0]  PIC_BASE_SHORT    = 3'h2;
    localparam logic [2:0]  PIC_BASE_LONG     = 3'h3;
    localparam logic [2:0]  PIC_BUSY_OFFSET   = 3'h2;
    localparam logic [1:0]  PIC_USE_WORD      = 2'h1;
    localparam logic [1:0]  PIC_USE_BYTE      = 2'h2;

    typedef enum logic [4:0] {
        KIND_OTHER                      = 5'h00,
        KIND_SINGLE_WORD_LOAD           = 5'h01,
        KIND_SINGLE_BYTE_LOAD           = 5'h02,
        KIND_SINGLE_WORD_STORE          = 5'h03,
        KIND_MULTI_REGISTER_LOAD        = 5'h04,
        KIND_MULTI_REGISTER_STORE       = 5'h05,
        KIND_ATOMIC_SWAP                = 5'h06,
        KIND_COPROC_MEM_LOAD            = 5'h07,
        KIND_COPROC_MEM_STORE           = 5'h08,
        KIND_CORE_TO_COPROC_MOVE        = 5'h09,
        KIND_COPROC_TO_CORE_MOVE        = 5'h0a,
        KIND_MULTIPLY_SHORT             = 5'h0b,
        KIND_MULTIPLY_ACCUMULATE_SHORT  = 5'h0c,
        KIND_SIGNED_LONG_MULTIPLY       = 5'h0d,
        KIND_SIGNED_LONG_MULTIPLY_ACC   = 5'h0e,
        KIND_UNSIGNED_LONG_MULTIPLY     = 5'h0f,
        KIND_UNSIGNED_LONG_MULTIPLY_ACC = 5'h10
    } pic_kind_t;

    typedef enum logic [1:0] {
        CYC_N = 2'h0,
        CYC_S = 2'h1,
        CYC_I = 2'h2,
        CYC_C = 2'h3
    } pic_cyc_t;

    typedef enum logic [1:0] {
        MS_IDLE = 2'h0,
        MS_LIST = 2'h1,
        MS_SEQ  = 2'h2
    } pic_mst_t;

    typedef struct packed {
        logic                 valid;
        pic_kind_t            kind;
        logic                 compact;
        logic [31:0]          instr;
        logic [2:0]           src_en;
        logic [PIC_REG_W-1:0] src_a;
        logic [PIC_REG_W-1:0] src_b;
        logic [PIC_REG_W-1:0] src_c;
        logic [PIC_NREG-1:0]  reg_list;
        logic [PIC_CNT_W-1:0] cp_words;
    } pic_dec_t;

    typedef struct packed {
        logic                 active;
        pic_cyc_t             cyc;
        logic [PIC_REG_W-1:0] xfer_reg;
    } pic_dbus_t;
endpackage
`default_nettype wire

// *** sim/pic_mem_model.sv ***
// Register file model that answers the multiplier operand read
`timescale 1ns/100ps
`default_nettype none
module pic_mem_model
    import pic_pkg::*;
(
    // Operand read
    input  wire  logic [PIC_REG_W-1:0] i_sel,
    output logic       [31:0]          o_data
);
    logic [31:0] rf [PIC_NREG];

    // Answers in the same cycle, as the register file read does
    assign o_data = rf[i_sel];
endmodule // pic_mem_model
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking testbench for the interlock and multiply timing block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pic_pkg::*;
    logic                 i_ref_clk = 1'b0;
    logic                 i_rst_b   = 1'b0;
    pic_dec_t             i_dec     = '0;
    logic [31:0]          mul_op;
    logic                 o_issue;
    logic                 o_fetch_en;
    logic                 o_interlock;
    pic_dbus_t            o_dbus;
    logic [PIC_REG_W-1:0] o_mul_reg_sel;
    logic [2:0]           o_mul_iter;
    logic [2:0]           o_mul_cycles;
    int                   failures  = 0;
    int                   n_checks  = 0;
    int                   cyc       = 0;
    int                   fetch_low = 0;
    int                   ilock_hi  = 0;
    pic_dbus_t            bq[$];

    pic_interlock i_dut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_dec(i_dec),
        .i_mul_operand(mul_op), .o_issue(o_issue), .o_fetch_en(o_fetch_en),
        .o_interlock(o_interlock), .o_dbus(o_dbus), .o_mul_reg_sel(o_mul_reg_sel),
        .o_mul_iter(o_mul_iter), .o_mul_cycles(o_mul_cycles));
    pic_mem_model i_mem (.i_sel(o_mul_reg_sel), .o_data(mul_op));

    always #4 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) cyc <= cyc + 1;
    // Outputs are registered, so the falling edge sees them settled
    always @(negedge i_ref_clk)
    begin
        if (o_dbus.active === 1'b1) bq.push_back(o_dbus);
        if (o_fetch_en === 1'b0) fetch_low++;
        if (o_interlock === 1'b1) ilock_hi++;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask

    function automatic pic_dec_t mk(pic_kind_t k, logic [2:0] en, logic [3:0] a);
        pic_dec_t d;
        d = '0;
        d.valid = 1'b1;
        d.kind = k;
        d.src_en = en;
        d.src_a = a;
        d.src_c = 4'h2;
        return d;
    endfunction

    // Holds the instruction until the issue pulse; returns its cycle
    task automatic issue(input pic_dec_t d, output int t);
        int k;
        @(negedge i_ref_clk);
        i_dec = d;
        for (k = 0; k < 64 && o_issue !== 1'b1; k++) @(negedge i_ref_clk);
        t = cyc;
        i_dec.valid = 1'b0;
    endtask

    task automatic load_use(input pic_kind_t k, input logic [3:0] use_r, input int gap);
        int t0;
        int t1;
        int f;
        int g;
        issue(mk(k, 3'h1, 4'h9), t0);
        f = fetch_low;
        g = ilock_hi;
        issue(mk(KIND_OTHER, 3'h1, use_r), t1);
        chk("load use gap", gap, t1 - t0);
        chk("fetch stop", gap > 2, fetch_low > f);
        chk("interlock flag", gap > 2, ilock_hi > g);
        idle(6);
    endtask

    task automatic list_use(input logic [3:0] use_r, input int gap);
        int t0;
        int t1;
        pic_dec_t d;
        d = mk(KIND_MULTI_REGISTER_LOAD, 3'h1, 4'hc);
        d.reg_list = 16'h001e;
        issue(d, t0);
        issue(mk(KIND_OTHER, 3'h1, use_r), t1);
        chk("list use gap", gap, t1 - t0);
        idle(8);
    endtask

    // Expected beats: first one c0, the rest sequential, list regs ascending
    task automatic bus_case(input pic_kind_t k, input logic [15:0] lst, input int n,
                            input pic_cyc_t c0);
        int t;
        int i;
        int r;
        pic_dec_t d;
        d = mk(k, 3'h0, 4'h0);
        d.reg_list = lst;
        d.cp_words = n[PIC_CNT_W-1:0];
        bq.delete();
        issue(d, t);
        idle(8);
        chk("beats", n, bq.size());
        chk("idle cycle", CYC_I, o_dbus.cyc);
        r = 0;
        for (i = 0; i < bq.size() && i < n; i++)
        begin
            chk("cycle type", (i == 0) ? c0 : CYC_S, bq[i].cyc);
            if (lst != 16'h0)
            begin
                while (r < 16 && !lst[r]) r++;
                chk("list reg", r, bq[i].xfer_reg);
                r++;
            end
        end
    endtask

    function automatic int exp_m(pic_kind_t k, logic [31:0] v);
        bit u;
        u = (k == KIND_UNSIGNED_LONG_MULTIPLY) || (k == KIND_UNSIGNED_LONG_MULTIPLY_ACC);
        if (v[31:8] == 0 || (!u && &v[31:8])) return 1;
        if (v[31:16] == 0 || (!u && &v[31:16])) return 2;
        if (v[31:24] == 0 || (!u && &v[31:24])) return 3;
        return 4;
    endfunction

    initial
    begin
        #(8 * 5000);
        failures++;
        finish_test();
    end

    initial
    begin
        int i;
        int r;
        int t0;
        int t1;
        int m;
        int base;
        logic [31:0] v;
        pic_kind_t k;
        pic_dec_t d;
        void'($urandom(48));
        repeat (6) @(negedge i_ref_clk);
        i_rst_b = 1'b1;
        chk("reset iter", 3'h1, o_mul_iter);
        chk("reset cycles", 3'h3, o_mul_cycles);
        chk("reset fetch", 1'b1, o_fetch_en);
        load_use(KIND_SINGLE_WORD_LOAD, 4'h2, 3);
        load_use(KIND_SINGLE_BYTE_LOAD, 4'h2, 4);
        load_use(KIND_SINGLE_WORD_LOAD, 4'h5, 2);
        list_use(4'h1, 4);
        list_use(4'h4, 5);
        $display("load interlock tests done");
        bus_case(KIND_SINGLE_WORD_LOAD, 16'h0, 1, CYC_N);
        bus_case(KIND_SINGLE_WORD_STORE, 16'h0, 1, CYC_N);
        bus_case(KIND_ATOMIC_SWAP, 16'h0, 2, CYC_N);
        bus_case(KIND_COPROC_MEM_LOAD, 16'h0, 3, CYC_N);
        bus_case(KIND_COPROC_MEM_STORE, 16'h0, 1, CYC_N);
        bus_case(KIND_CORE_TO_COPROC_MOVE, 16'h0, 1, CYC_C);
        bus_case(KIND_COPROC_TO_CORE_MOVE, 16'h0, 1, CYC_C);
        bus_case(KIND_MULTI_REGISTER_LOAD, 16'h001e, 4, CYC_N);
        bus_case(KIND_MULTI_REGISTER_STORE, 16'h8421, 4, CYC_N);
        $display("data bus tests done");
        for (i = 0; i < 48; i++)
        begin
            k = pic_kind_t'(5'(11 + $urandom_range(5)));
            r = $urandom_range(15);
            v = $urandom >> (8 * $urandom_range(3));
            if ($urandom_range(1)) v = ~v;
            d = mk(k, 3'h0, 4'h0);
            d.compact = (k == KIND_MULTIPLY_SHORT) && $urandom_range(1);
            d.instr = $urandom;
            if (d.compact) r = r & 7;
            if (d.compact) d.instr[2:0] = r[2:0];
            else d.instr[11:8] = r[3:0];
            i_mem.rf[r] = v;
            issue(d, t0);
            chk("multiplier select", r, o_mul_reg_sel);
            m = exp_m(k, v);
            base = (k <= KIND_MULTIPLY_ACCUMULATE_SHORT) ? 2 : 3;
            @(negedge i_ref_clk);
            chk("early termination", m, o_mul_iter);
            chk("multiply cycles", base + m, o_mul_cycles);
            issue(mk(KIND_OTHER, 3'h0, 4'h0), t1);
            chk("multiply spacing", base + m, t1 - t0);
        end
        $display("multiply tests done");
        finish_test();
    end
endmodule // tb
`default_nettype wire
